// >>> inc/sbm_pkg.sv
package sbm_pkg;
   // Clock and timing
   localparam int CLK_MHZ       = 10;
   localparam int READY_TIME_US = 2000000;
   localparam int READY_CYCLES  = READY_TIME_US * CLK_MHZ;
   localparam int RESP_TIME_US  = 50;
   localparam int RESP_CYCLES   = RESP_TIME_US * CLK_MHZ;
   localparam int MAX_TRIES     = 3;

   // Topology limits
   localparam int NUM_PKG  = 8;
   localparam int NUM_CH   = 4;
   localparam int MAP_DEPTH = NUM_PKG * NUM_CH;
   localparam int MAP_AW   = 5;
   localparam logic [2:0] LAST_PKG = 3'h7;
   localparam logic [4:0] CH_PKG   = 5'h1f;
   localparam logic [4:0] CH_MAX   = 5'h04;
   localparam logic [2:0] CFG_LAST = 3'h4;

   // Command codes, response code is command or RSP_FLAG
   localparam logic [7:0] OP_CIS    = 8'h00;
   localparam logic [7:0] OP_SEL    = 8'h01;
   localparam logic [7:0] OP_DESEL  = 8'h02;
   localparam logic [7:0] OP_ENCH   = 8'h03;
   localparam logic [7:0] OP_NTX_EN = 8'h06;
   localparam logic [7:0] OP_NTX_DI = 8'h07;
   localparam logic [7:0] OP_AEN    = 8'h08;
   localparam logic [7:0] OP_MAC    = 8'h0e;
   localparam logic [7:0] OP_BCAST  = 8'h10;
   localparam logic [7:0] OP_GVI    = 8'h15;
   localparam logic [7:0] OP_GCAP   = 8'h16;
   localparam logic [7:0] RSP_FLAG  = 8'h80;
   localparam logic [47:0] PRM_ARB_ON  = 48'h1;
   localparam logic [47:0] PRM_ARB_OFF = 48'h0;

   // Register byte offsets and response codes
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_AEN    = 8'h04;
   localparam logic [7:0] REG_TMO    = 8'h08;
   localparam logic [7:0] REG_STAT   = 8'h0c;
   localparam logic [7:0] REG_MAPSEL = 8'h10;
   localparam logic [7:0] REG_MAPDAT = 8'h14;
   localparam logic [7:0] REG_MACLO  = 8'h18;
   localparam logic [7:0] REG_MACHI  = 8'h1c;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [2:0]  pkg;
      logic [4:0]  ch;
      logic [47:0] param;
   } sbm_cmd_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [2:0] pkg;
      logic [4:0] ch;
      logic [7:0] version;
      logic [4:0] chan_cnt;
      logic       arb_ok;
   } sbm_rsp_t;

   typedef struct packed {
      logic       valid;
      logic       arb_ok;
      logic [4:0] chan_cnt;
      logic [7:0] version;
   } sbm_entry_t;

   typedef struct packed {
      logic [27:0] rsvd;
      logic        bcast_accept;
      logic        net_tx_en;
      logic        arb_allow;
      logic        start;
   } sbm_ctrl_t;

   typedef struct packed {
      logic [15:0] rsvd;
      logic [7:0]  present;
      logic [3:0]  pkg_cnt;
      logic        arb_on;
      logic        sel_open;
      logic        done;
      logic        busy;
   } sbm_status_t;

   typedef enum logic [3:0] {
      P_SEL, P_CIS, P_GVI, P_GCAP, P_DESEL,
      P_ISEL, P_CFG, P_IDESEL, P_ARB
   } sbm_phase_t;

   typedef enum logic [2:0] {
      S_IDLE, S_READY, S_PLAN, S_SEND, S_WAIT, S_NEXT, S_DONE
   } sbm_state_t;
endpackage : sbm_pkg

// >>> rtl/sbm_timer.sv
`timescale 1ns/100ps
module sbm_timer
   import sbm_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        load,
   input  wire logic [31:0] load_val,
   output logic             expired
);
   logic [31:0] count_q;
   logic        run_q;
   logic        exp_q;

   // Expiry holds until the next load so the waiter cannot miss it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 32'h0;
         run_q   <= 1'b0;
         exp_q   <= 1'b0;
      end else if (load) begin
         count_q <= load_val;
         run_q   <= 1'b1;
         exp_q   <= 1'b0;
      end else if (run_q) begin
         if (count_q <= 32'h1) begin
            run_q <= 1'b0;
            exp_q <= 1'b1;
         end else begin
            count_q <= count_q - 32'h1;
         end
      end
   end

   assign expired = exp_q;
endmodule : sbm_timer

// >>> rtl/sbm_map_mem.sv
`timescale 1ns/100ps
module sbm_map_mem
   import sbm_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              we,
   input  wire logic [MAP_AW-1:0] waddr,
   input  wire sbm_entry_t        wdata,
   input  wire logic [MAP_AW-1:0] raddr,
   output sbm_entry_t             rdata
);
   sbm_entry_t mem_q [MAP_DEPTH];
   sbm_entry_t rdata_q;

   always_ff @(posedge aclk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
   end

   assign rdata = rdata_q;
endmodule : sbm_map_mem

// >>> rtl/sbm_ctrl.sv
// Behaviour
// - Wait device ready interval before commands
// - Discover packages from lowest ID, arbitration off
// - Retry unanswered command, three tries total
// - All tries failed: package absent, next
// - Clear state per channel, then version, capabilities
// - Iterate channels up to first reported count, capped at CH_MAX
// - Keep capabilities including arbitration support
// - Deselect current package before selecting next
// - Never more than one package selected; a restart after arbitration leaves the arbitrated packages selected
// - Init: select, configure channels, deselect
// - Single package: arbitration may stay disabled
// - Many capable packages: select with arbitration on
// - With arbitration, no deselects needed
// - Arbitration wiring must be known beforehand
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module sbm_ctrl
   import sbm_pkg::*;
#(
   parameter int READY_WAIT = READY_CYCLES
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output sbm_cmd_t         cmd,
   output logic             cmd_valid,
   input  wire logic        cmd_ready,
   input  wire sbm_rsp_t    rsp,
   input  wire logic        rsp_valid
);
   sbm_ctrl_t   ctrl_q;
   logic [31:0] aen_q, tmo_q, maclo_q, machi_q;
   logic [MAP_AW-1:0] mapsel_q;
   logic        start_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, wmask, rdata_q;
   logic        aw_got_q, w_got_q;
   sbm_status_t stat;
   sbm_entry_t  map_rd, map_wd;

   sbm_state_t  state_q;
   sbm_phase_t  phase_q;
   sbm_cmd_t    cmd_q;
   sbm_rsp_t    rsp_q;
   logic        cmd_valid_q, ok_q, ready_done_q, done_q, sel_open_q;
   logic        arb_all_q, arb_on_q;
   logic [2:0]  pkg_q, cfg_q;
   logic [4:0]  ch_q, chan_total_q;
   logic [1:0]  tries_q;
   logic [3:0]  pkg_cnt_q;
   logic [7:0]  pres_q;
   logic [4:0]  chans_q [NUM_PKG];
   logic        rsp_match, tmr_load, tmr_exp, mem_we;
   logic [31:0] tmr_val;
   logic [4:0]  cnt_lim, ch_next;

   default clocking sbm_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ---------------- Register slave ----------------
   assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                   {8{wstrb[1]}}, {8{wstrb[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= 8'h0;
         wdata_q   <= 32'h0;
         ctrl_q    <= '0;
         aen_q     <= 32'h0;
         tmo_q     <= RESP_CYCLES;
         maclo_q   <= 32'h0;
         machi_q   <= 32'h0;
         mapsel_q  <= '0;
         start_q   <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (awvalid && awready_q) begin
            awaddr_q  <= awaddr;
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            wdata_q  <= wdata & wmask;
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
         end
         if (aw_got_q && w_got_q && !bvalid_q) begin
            bvalid_q <= 1'b1;
            bresp_q  <= RESP_OKAY;
            case (awaddr_q)
               REG_CTRL: begin
                  ctrl_q <= sbm_ctrl_t'(wdata_q);
                  start_q <= wdata_q[0] && !stat.busy;
               end
               REG_AEN:    aen_q <= wdata_q;
               REG_TMO:    tmo_q <= wdata_q;
               REG_MAPSEL: mapsel_q <= wdata_q[MAP_AW-1:0];
               REG_MACLO:  maclo_q <= wdata_q;
               REG_MACHI:  machi_q <= wdata_q;
               REG_STAT, REG_MAPDAT: bresp_q <= RESP_OKAY;
               default:    bresp_q <= RESP_DECERR;
            endcase
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
         ctrl_q.start <= 1'b0;
      end
   end

   assign stat = '{rsvd: 16'h0, present: pres_q, pkg_cnt: pkg_cnt_q,
                   arb_on: arb_on_q, sel_open: sel_open_q,
                   done: done_q,
                   busy: (state_q != S_IDLE) && (state_q != S_DONE)};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= RESP_OKAY;
         case (araddr)
            REG_CTRL:   rdata_q <= 32'(ctrl_q);
            REG_AEN:    rdata_q <= aen_q;
            REG_TMO:    rdata_q <= tmo_q;
            REG_STAT:   rdata_q <= 32'(stat);
            REG_MAPSEL: rdata_q <= 32'(mapsel_q);
            REG_MAPDAT: rdata_q <= 32'(map_rd);
            REG_MACLO:  rdata_q <= maclo_q;
            REG_MACHI:  rdata_q <= machi_q;
            default: begin
               rdata_q <= 32'h0;
               rresp_q <= RESP_DECERR;
            end
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ---------------- Sequencer ----------------
   assign rsp_match = rsp_valid && (state_q == S_WAIT)
                      && rsp.opcode == (cmd_q.opcode | RSP_FLAG)
                      && rsp.pkg == cmd_q.pkg && rsp.ch == cmd_q.ch;
   // A restart from done must wait the full ready interval again
   assign tmr_load  = ((state_q == S_IDLE || state_q == S_DONE) && start_q)
                      || (state_q == S_SEND && cmd_ready);
   assign tmr_val   = (state_q == S_SEND) ? tmo_q : READY_WAIT;
   assign cnt_lim   = (rsp_q.chan_cnt > CH_MAX) ? CH_MAX : rsp_q.chan_cnt;
   assign ch_next   = ch_q + 5'h1;
   assign mem_we    = state_q == S_NEXT && phase_q == P_GCAP && ok_q;
   assign map_wd    = '{valid: 1'b1, arb_ok: rsp_q.arb_ok,
                        chan_cnt: rsp_q.chan_cnt, version: rsp_q.version};

   sbm_timer u_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_exp)
   );

   sbm_map_mem u_map (
      .aclk  (aclk),
      .we    (mem_we),
      .waddr ({pkg_q, ch_q[1:0]}),
      .wdata (map_wd),
      .raddr (mapsel_q),
      .rdata (map_rd)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q      <= S_IDLE;
         phase_q      <= P_SEL;
         cmd_q        <= '0;
         cmd_valid_q  <= 1'b0;
         rsp_q        <= '0;
         ok_q         <= 1'b0;
         ready_done_q <= 1'b0;
         done_q       <= 1'b0;
         sel_open_q   <= 1'b0;
         arb_all_q    <= 1'b1;
         arb_on_q     <= 1'b0;
         pkg_q        <= 3'h0;
         cfg_q        <= 3'h0;
         ch_q         <= 5'h0;
         chan_total_q <= 5'h0;
         tries_q      <= 2'h0;
         pkg_cnt_q    <= 4'h0;
         pres_q       <= 8'h0;
         for (int i = 0; i < NUM_PKG; i++) chans_q[i] <= 5'h0;
      end else begin
         case (state_q)
            S_IDLE, S_DONE: if (start_q) begin
               state_q <= S_READY;
               ready_done_q <= 1'b0; done_q <= 1'b0;
               pres_q <= 8'h0; pkg_cnt_q <= 4'h0; arb_on_q <= 1'b0;
               arb_all_q <= 1'b1; pkg_q <= 3'h0; phase_q <= P_SEL;
            end
            S_READY: if (tmr_exp) begin
               ready_done_q <= 1'b1;
               state_q <= S_PLAN;
            end
            S_PLAN: begin
               state_q <= S_SEND;
               cmd_valid_q <= 1'b1;
               cmd_q.pkg   <= pkg_q;
               cmd_q.ch    <= ch_q;
               cmd_q.param <= PRM_ARB_OFF;
               case (phase_q)
                  P_SEL, P_ISEL: begin
                     cmd_q.opcode <= OP_SEL;
                     cmd_q.ch <= CH_PKG;
                  end
                  P_CIS:  cmd_q.opcode <= OP_CIS;
                  P_GVI:  cmd_q.opcode <= OP_GVI;
                  P_GCAP: cmd_q.opcode <= OP_GCAP;
                  P_DESEL, P_IDESEL: begin
                     cmd_q.opcode <= OP_DESEL;
                     cmd_q.ch <= CH_PKG;
                  end
                  P_CFG: case (cfg_q)
                     3'h0: begin
                        cmd_q.opcode <= OP_MAC;
                        cmd_q.param <= {machi_q[15:0], maclo_q};
                     end
                     3'h1: begin
                        cmd_q.opcode <= OP_BCAST;
                        cmd_q.param <= 48'(ctrl_q.bcast_accept);
                     end
                     3'h2: begin
                        cmd_q.opcode <= OP_AEN;
                        cmd_q.param <= 48'(aen_q);
                     end
                     3'h3: cmd_q.opcode <= ctrl_q.net_tx_en ?
                                           OP_NTX_EN : OP_NTX_DI;
                     default: cmd_q.opcode <= OP_ENCH;
                  endcase
                  P_ARB: begin
                     cmd_q.opcode <= OP_SEL;
                     cmd_q.ch <= CH_PKG;
                     cmd_q.param <= PRM_ARB_ON;
                  end
                  default: cmd_q.opcode <= OP_CIS;
               endcase
               if ((phase_q == P_ISEL || phase_q == P_IDESEL
                    || phase_q == P_ARB) && !pres_q[pkg_q]) begin
                  cmd_valid_q <= 1'b0;
                  ok_q <= 1'b0;
                  state_q <= S_NEXT;
               end
            end
            S_SEND: if (cmd_ready) begin
               cmd_valid_q <= 1'b0;
               state_q <= S_WAIT;
            end
            S_WAIT: if (rsp_match) begin
               rsp_q <= rsp;
               ok_q <= 1'b1;
               tries_q <= 2'h0;
               state_q <= S_NEXT;
            end else if (tmr_exp) begin
               if (32'(tries_q) == MAX_TRIES - 1) begin
                  ok_q <= 1'b0;
                  tries_q <= 2'h0;
                  state_q <= S_NEXT;
               end else begin
                  tries_q <= tries_q + 2'h1;
                  cmd_valid_q <= 1'b1;
                  state_q <= S_SEND;
               end
            end
            S_NEXT: begin
               state_q <= S_PLAN;
               case (phase_q)
                  P_SEL: if (ok_q) begin
                     pres_q[pkg_q] <= 1'b1;
                     pkg_cnt_q <= pkg_cnt_q + 4'h1;
                     sel_open_q <= 1'b1;
                     ch_q <= 5'h0;
                     chan_total_q <= CH_MAX;
                     phase_q <= P_CIS;
                  end else if (pkg_q == LAST_PKG) begin
                     pkg_q <= 3'h0;
                     phase_q <= P_ISEL;
                  end else begin
                     pkg_q <= pkg_q + 3'h1;
                  end
                  P_CIS: phase_q <= ok_q ? P_GVI : P_DESEL;
                  P_GVI: phase_q <= P_GCAP;
                  P_GCAP: begin
                     if (ok_q) begin
                        arb_all_q <= arb_all_q & rsp_q.arb_ok;
                        chans_q[pkg_q] <= ch_next;
                        if (ch_q == 5'h0) chan_total_q <= cnt_lim;
                     end
                     if (ok_q && ch_next < ((ch_q == 5'h0) ? cnt_lim
                                            : chan_total_q)) begin
                        ch_q <= ch_next;
                        phase_q <= P_CIS;
                     end else begin
                        phase_q <= P_DESEL;
                     end
                  end
                  P_DESEL, P_IDESEL: begin
                     sel_open_q <= 1'b0;
                     ch_q <= 5'h0;
                     if (pkg_q != LAST_PKG) begin
                        pkg_q <= pkg_q + 3'h1;
                        phase_q <= (phase_q == P_DESEL) ? P_SEL : P_ISEL;
                     end else begin
                        pkg_q <= 3'h0;
                        if (phase_q == P_DESEL) begin
                           phase_q <= P_ISEL;
                        end else if (ctrl_q.arb_allow && arb_all_q
                                     && pkg_cnt_q > 4'h1) begin
                           phase_q <= P_ARB;
                        end else begin
                           state_q <= S_DONE;
                           done_q <= 1'b1;
                        end
                     end
                  end
                  P_ISEL: begin
                     sel_open_q <= ok_q;
                     ch_q <= 5'h0;
                     cfg_q <= 3'h0;
                     phase_q <= (ok_q && chans_q[pkg_q] != 5'h0) ?
                                P_CFG : P_IDESEL;
                  end
                  P_CFG: if (cfg_q != CFG_LAST) begin
                     cfg_q <= cfg_q + 3'h1;
                  end else begin
                     cfg_q <= 3'h0;
                     if (ch_next < chans_q[pkg_q]) ch_q <= ch_next;
                     else phase_q <= P_IDESEL;
                  end
                  P_ARB: begin
                     if (ok_q) arb_on_q <= 1'b1;
                     if (pkg_q == LAST_PKG) begin
                        state_q <= S_DONE;
                        done_q <= 1'b1;
                     end else begin
                        pkg_q <= pkg_q + 3'h1;
                     end
                  end
                  default: state_q <= S_DONE;
               endcase
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign cmd     = cmd_q;
   assign cmd_valid = cmd_valid_q;

   // ---------------- Checks ----------------
   ready_wait_a: assert property (cmd_valid_q |-> ready_done_q)
      else $error("command before ready");
   ready_fresh_a: assert property (
      state_q == S_READY && $past(state_q) != S_READY |-> !tmr_exp)
      else $error("stale ready expiry");
   disc_sel_a: assert property (
      cmd_valid_q && phase_q == P_SEL |-> cmd_q.opcode == OP_SEL
      && cmd_q.param == PRM_ARB_OFF) else $error("bad discovery select");
   try_limit_a: assert property (32'(tries_q) < MAX_TRIES)
      else $error("too many tries");
   skip_pkg_a: assert property (
      state_q == S_NEXT && phase_q == P_SEL && !ok_q && pkg_q != LAST_PKG
      |=> state_q == S_PLAN && phase_q == P_SEL
      && pkg_q == $past(pkg_q) + 3'h1)
      else $error("absent pkg not skipped");
   chan_lim_a: assert property (
      $rose(cmd_valid_q) && cmd_q.opcode == OP_CIS |-> ch_q < chan_total_q)
      else $error("channel beyond count");
   one_sel_a: assert property (
      $rose(cmd_valid_q) && cmd_q.opcode == OP_SEL && !arb_on_q
      && phase_q != P_ARB |-> !sel_open_q) else $error("second select open");
   arb_en_a: assert property (
      cmd_valid_q && cmd_q.param == PRM_ARB_ON && cmd_q.opcode == OP_SEL
      |-> arb_all_q && pkg_cnt_q > 4'h1) else $error("arbitration misused");
   retry_a: assert property (
      state_q == S_WAIT && tmr_exp && !rsp_match && tries_q != 2'h2
      |=> state_q == S_SEND && cmd_valid_q) else $error("no retry");
   map_wr_a: assert property (
      state_q == S_WAIT && rsp_match && cmd_q.opcode == OP_GCAP
      |=> mem_we) else $error("capabilities not stored");
endmodule : sbm_ctrl

// >>> testbench/sbm_nc_model.sv
`timescale 1ns/100ps
module sbm_nc_model
   import sbm_pkg::*;
#(
   parameter logic [7:0] PRESENT = 8'h05,
   parameter logic [4:0] CHANS   = 5'h02
)(
   input  wire logic     aclk,
   input  wire sbm_cmd_t cmd,
   input  wire logic     cmd_valid,
   output logic          cmd_ready,
   output sbm_rsp_t      rsp,
   output logic          rsp_valid,
   output int            sel_err
);
   sbm_cmd_t   c_q;
   logic [7:0] sel_q = 8'h00;
   logic       arb_q = 1'b0;
   logic       tx_q  = 1'b0;
   logic       bc_q  = 1'b0;
   logic       aen_q = 1'b0;
   int         wait_q = 0;
   wire        pkg_op = c_q.opcode inside {OP_SEL, OP_DESEL};
   wire        hit = PRESENT[c_q.pkg] &&
                     (pkg_op ? c_q.ch == CH_PKG : c_q.ch < CHANS);
   initial begin
      cmd_ready = 1'b1;
      rsp_valid = 1'b0;
      rsp = '0;
      sel_err = 0;
   end
   always @(posedge aclk) begin
      rsp_valid <= 1'b0;
      rsp <= ~rsp; // Idle lines never hold a stale match
      if (cmd_valid && cmd_ready) begin
         c_q <= cmd;
         cmd_ready <= 1'b0;
         wait_q <= cmd.ch[0] ? 6 : 2; // Mix prompt and slow answers
      end
      if (wait_q > 0) wait_q <= wait_q - 1;
      if (wait_q == 1) begin
         cmd_ready <= 1'b1;
         if (hit) begin
            rsp_valid <= 1'b1;
            rsp <= '{c_q.opcode | RSP_FLAG, c_q.pkg, c_q.ch, 8'h11,
                     CHANS, 1'b1};
            if (c_q.opcode == OP_SEL) begin
               sel_q[c_q.pkg] <= 1'b1;
               arb_q <= c_q.param[0];
            end
            if (c_q.opcode == OP_DESEL) sel_q[c_q.pkg] <= 1'b0;
            if (c_q.opcode inside {OP_NTX_EN, OP_NTX_DI})
               tx_q <= c_q.opcode == OP_NTX_EN;
            if (c_q.opcode == OP_BCAST)
               bc_q <= c_q.param[0];
            if (c_q.opcode == OP_AEN) aen_q <= |c_q.param;
         end
      end
      if (!arb_q && $countones(sel_q) > 1) sel_err <= sel_err + 1;
   end
endmodule : sbm_nc_model

// >>> testbench/tb_sideband_passthru_startup.sv
`timescale 1ns/100ps
module tb_sideband_passthru_startup import sbm_pkg::*;;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready;
   logic        rvalid, cmd_valid, cmd_ready, rsp_valid;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp;
   sbm_cmd_t    cmd;
   sbm_rsp_t    rsp;
   int          mismatches = 0, num_checks = 0, sel_err;
   always #50 aclk = ~aclk;
   sbm_ctrl #(.READY_WAIT(20)) i_sbm_ctrl (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .cmd, .cmd_valid, .cmd_ready, .rsp, .rsp_valid);
   sbm_nc_model i_sbm_nc_model (.aclk, .cmd, .cmd_valid, .cmd_ready, .rsp,
      .rsp_valid, .sel_err);
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
      join
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
      chk("bresp", {30'h0, e}, {30'h0, bresp});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [1:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      // Rready stays up between reads; each read drives it high again and none drives it low
      v = rdata;
      chk("rresp", {30'h0, e}, {30'h0, rresp});
   endtask : rd
   task automatic run(input logic [31:0] ctl, input logic [31:0] st);
      wr(REG_CTRL, ctl, RESP_OKAY);
      repeat (2) @(posedge aclk);
      rd(REG_STAT, RESP_OKAY);
      for (int i = 0; i < 3000 && v[0] !== 1'b0; i++) rd(REG_STAT, RESP_OKAY);
      chk("stat", st, v);
   endtask : run
   task automatic results;
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wr(REG_TMO, 32'ha, RESP_OKAY);
      rd(REG_TMO, RESP_OKAY);
      chk("tmo", 32'ha, v);
      wr(8'h40, 32'h1, RESP_DECERR);
      rd(8'h40, RESP_DECERR);
      chk("unmapped", 32'h0, v);
      run(32'hf, 32'h052a);
      chk("ntx on", 32'h1, {31'h0, i_sbm_nc_model.tx_q});
      chk("arb on", 32'h1, {31'h0, i_sbm_nc_model.arb_q});
      chk("one sel", 32'h0, sel_err);
      wr(REG_MAPSEL, 32'h1, RESP_OKAY);
      rd(REG_MAPDAT, RESP_OKAY);
      chk("map", 32'h6211, v);
      run(32'h1, 32'h0522);
      chk("ntx off", 32'h0, {31'h0, i_sbm_nc_model.tx_q});
      chk("arb off", 32'h0, {31'h0, i_sbm_nc_model.arb_q});
      results();
   end
   initial begin
      #(20000 * 100);
      mismatches++;
      results();
   end
endmodule : tb_sideband_passthru_startup
